/* rtl/hlt_pkg.sv */
// shared constants and types for the period timer block
package hlt_pkg;

  // bus address layout: instance in bits 5:4, register in bits 3:2
  localparam int          ADR_W         = 8;
  localparam int          INST_LSB      = 4;
  localparam int          REG_LSB       = 2;
  localparam logic [1:0]  REG_COUNT     = 2'h0;
  localparam logic [1:0]  REG_PERIOD    = 2'h1;
  localparam logic [1:0]  REG_CTRL      = 2'h2;
  localparam logic [1:0]  REG_CTRL1     = 2'h3;

  // timer_control fields
  localparam int          CTRL_RUN_BIT  = 7;
  localparam int          CTRL_PRE_LSB  = 4;
  localparam int          CTRL_POST_LSB = 0;

  // timer_control_1 fields
  localparam int          CTRL1_MODE_LSB = 0;
  localparam int          CTRL1_SYNC_BIT = 4;
  localparam int          CTRL1_SRC_LSB  = 8;
  localparam int          CTRL1_FLAG_BIT = 16;
  localparam int          CTRL1_IEN_BIT  = 17;

  // values after reset
  localparam logic [7:0]  COUNT_RST     = 8'h00;
  localparam logic [7:0]  PERIOD_RST    = 8'hFF;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [3:0]  MODE_RST      = 4'h0;
  localparam logic        SYNC_RST      = 1'b1;
  localparam logic [6:0]  PRESC_RST     = 7'h00;
  localparam logic [3:0]  POST_RST      = 4'h0;

  // limit modes
  localparam logic [3:0]  MODE_SW_GATE   = 4'h0;
  localparam logic [3:0]  MODE_GATE_HI   = 4'h1;
  localparam logic [3:0]  MODE_GATE_LO   = 4'h2;
  localparam logic [3:0]  MODE_RST_ANY   = 4'h3;
  localparam logic [3:0]  MODE_RST_RISE  = 4'h4;
  localparam logic [3:0]  MODE_RST_FALL  = 4'h5;
  localparam logic [3:0]  MODE_RST_LOW   = 4'h6;
  localparam logic [3:0]  MODE_RST_HIGH  = 4'h7;
  localparam logic [3:0]  MODE_OS_SW     = 4'h8;
  localparam logic [3:0]  MODE_OS_RISE   = 4'h9;
  localparam logic [3:0]  MODE_OS_FALL   = 4'hA;
  localparam logic [3:0]  MODE_OS_ANY    = 4'hB;
  localparam logic [3:0]  MODE_OS_RR     = 4'hC;
  localparam logic [3:0]  MODE_OS_FF     = 4'hD;
  localparam logic [3:0]  MODE_OS_RLOW   = 4'hE;
  localparam logic [3:0]  MODE_OS_FHIGH  = 4'hF;

  // per-instance signals exported to the pwm unit and trigger users
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period;
    logic       match;
    logic       postscaled;
    logic       irq;
  } hlt_out_t;

endpackage

/* rtl/hlt_timer.sv */
// three 8-bit period timers with hardware limit, behind a wishbone slave
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns

// Summary of operation
// - 8-bit count and period registers each
// - prescaler divides by 1 to 128
// - postscaler counts matches, ratios 1 to 16
// - reset clears count, period becomes FFh
// - count and period readable, writable any time
// - pre/postscaler cleared by count/control writes, reset, ext
// - control write leaves count unchanged
// - match zeroes count next, advances postscaler
// - postscale equal gives one-clock pulse, clears
// - one-shot match clears run, halts counter
// - one-shot restart resets the postscaler
// - postscaled match sets flag, enable gates request
// - postscaled pulse exported as trigger output
// - count and match exported to pwm
// - selected ext signal starts, stops, resets
// - edge pulses need six clocks spacing
// - level must hold three clocks
// - ext reset acts regardless of freeze
// - run and ext synchronised two cycles
// - three identical instances, own registers
// - software gate: count only while run
// - modes 0001/0010 gate on ext level
// - modes 0011/0100/0101 reset on edges
// - mode 1000 software-started one-shot
module hlt_timer #(
  parameter int NT    = 3,
  parameter int NSRC  = 8,
  parameter int SRC_W = 3
) (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [hlt_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // external reset sources, shared by all instances
  input  wire logic [NSRC-1:0]           ext_reset_i,
  // per-instance exports
  output hlt_pkg::hlt_out_t              tmr_o [NT]
);

  logic        ack_ff;
  logic [31:0] dat_ff;
  logic        bus_req;
  logic        bus_wr;
  logic [1:0]  bus_inst;
  logic [1:0]  bus_reg;
  logic [31:0] nxt_dat;

  logic [7:0]       count_ff   [NT];
  logic [7:0]       period_ff  [NT];
  logic             run_ff     [NT];
  logic [2:0]       pre_sel_ff [NT];
  logic [3:0]       post_sel_ff[NT];
  logic [3:0]       mode_ff    [NT];
  logic             sync_ff    [NT];
  logic [SRC_W-1:0] src_ff     [NT];
  logic             flag_ff    [NT];
  logic             ien_ff     [NT];
  hlt_pkg::hlt_out_t out_ff    [NT];

  // prescaler terminal count for a 1:2^sel ratio
  function automatic logic [6:0] pre_mask(input logic [2:0] sel);
    logic [7:0] one_hot;
    one_hot = 8'h01 << sel;
    return 7'(one_hot - 8'h01);
  endfunction

  assign bus_req  = wb_cyc_i & wb_stb_i;
  // write lands on the edge where ack is seen high
  assign bus_wr   = bus_req & wb_we_i & ack_ff;
  assign bus_inst = wb_adr_i[hlt_pkg::INST_LSB +: 2];
  assign bus_reg  = wb_adr_i[hlt_pkg::REG_LSB +: 2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  // unmapped instance slots read zero and ignore writes
  always_comb begin
    nxt_dat = 32'h0000_0000;
    if (32'(bus_inst) < NT) begin
      case (bus_reg)
        hlt_pkg::REG_COUNT:  nxt_dat[7:0] = count_ff[bus_inst];
        hlt_pkg::REG_PERIOD: nxt_dat[7:0] = period_ff[bus_inst];
        hlt_pkg::REG_CTRL: begin
          nxt_dat[hlt_pkg::CTRL_RUN_BIT]         = run_ff[bus_inst];
          nxt_dat[hlt_pkg::CTRL_PRE_LSB +: 3]    = pre_sel_ff[bus_inst];
          nxt_dat[hlt_pkg::CTRL_POST_LSB +: 4]   = post_sel_ff[bus_inst];
        end
        hlt_pkg::REG_CTRL1: begin
          nxt_dat[hlt_pkg::CTRL1_MODE_LSB +: 4]  = mode_ff[bus_inst];
          nxt_dat[hlt_pkg::CTRL1_SYNC_BIT]       = sync_ff[bus_inst];
          nxt_dat[hlt_pkg::CTRL1_SRC_LSB +: SRC_W] = src_ff[bus_inst];
          nxt_dat[hlt_pkg::CTRL1_FLAG_BIT]       = flag_ff[bus_inst];
          nxt_dat[hlt_pkg::CTRL1_IEN_BIT]        = ien_ff[bus_inst];
        end
        default: nxt_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (bus_req & ~ack_ff) begin
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  for (genvar i = 0; i < NT; i++) begin : g_tmr
    logic       sel_me;
    logic       wr_cnt;
    logic       wr_per;
    logic       wr_ctl;
    logic       wr_ctl1;
    logic       run_s1_ff;
    logic       run_s2_ff;
    logic       ext_s1_ff;
    logic       ext_s2_ff;
    logic       ext_prev_ff;
    logic       run_prev_ff;
    logic       started_ff;
    logic       done_ff;
    logic [6:0] presc_ff;
    logic [3:0] post_ff;
    logic       run_v;
    logic       ext_v;
    logic       rise;
    logic       fall;
    logic       run_rise;
    logic       one_shot;
    logic       gate_ok;
    logic       start_edge;
    logic       rst_evt;
    logic       counting;
    logic       tick;
    logic       match;
    logic       post_hit;
    logic       scale_clr;

    assign sel_me  = (bus_inst == 2'(i));
    assign wr_cnt  = bus_wr & sel_me & (bus_reg == hlt_pkg::REG_COUNT) & wb_sel_i[0];
    assign wr_per  = bus_wr & sel_me & (bus_reg == hlt_pkg::REG_PERIOD) & wb_sel_i[0];
    assign wr_ctl  = bus_wr & sel_me & (bus_reg == hlt_pkg::REG_CTRL) & wb_sel_i[0];
    assign wr_ctl1 = bus_wr & sel_me & (bus_reg == hlt_pkg::REG_CTRL1);

    // two-stage sync of run and ext
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        run_s1_ff <= 1'b0;
        run_s2_ff <= 1'b0;
        ext_s1_ff <= 1'b0;
        ext_s2_ff <= 1'b0;
      end else begin
        run_s1_ff <= run_ff[i];
        run_s2_ff <= run_s1_ff;
        ext_s1_ff <= ext_reset_i[src_ff[i]];
        ext_s2_ff <= ext_s1_ff;
      end
    end

    // bypass only when software clears sync
    assign run_v = sync_ff[i] ? run_s2_ff : run_ff[i];
    assign ext_v = sync_ff[i] ? ext_s2_ff : ext_reset_i[src_ff[i]];

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ext_prev_ff <= 1'b0;
        run_prev_ff <= 1'b0;
      end else begin
        ext_prev_ff <= ext_v;
        run_prev_ff <= run_v;
      end
    end

    // edges seen on the synchronised level
    assign rise     = ext_v & ~ext_prev_ff;
    assign fall     = ~ext_v & ext_prev_ff;
    assign run_rise = run_v & ~run_prev_ff;
    assign one_shot = mode_ff[i][3];

    always_comb begin
      gate_ok    = 1'b1;
      start_edge = 1'b0;
      rst_evt    = 1'b0;
      case (mode_ff[i])
        hlt_pkg::MODE_SW_GATE:  gate_ok = 1'b1;
        hlt_pkg::MODE_GATE_HI:  gate_ok = ~ext_v;
        hlt_pkg::MODE_GATE_LO:  gate_ok = ext_v;
        hlt_pkg::MODE_RST_ANY:  rst_evt = rise | fall;
        hlt_pkg::MODE_RST_RISE: rst_evt = rise;
        hlt_pkg::MODE_RST_FALL: rst_evt = fall;
        hlt_pkg::MODE_RST_LOW:  rst_evt = ~ext_v;
        hlt_pkg::MODE_RST_HIGH: rst_evt = ext_v;
        hlt_pkg::MODE_OS_SW:    start_edge = 1'b1;
        hlt_pkg::MODE_OS_RISE:  start_edge = rise;
        hlt_pkg::MODE_OS_FALL:  start_edge = fall;
        hlt_pkg::MODE_OS_ANY:   start_edge = rise | fall;
        hlt_pkg::MODE_OS_RR: begin
          start_edge = rise;
          rst_evt    = started_ff & rise;
        end
        hlt_pkg::MODE_OS_FF: begin
          start_edge = fall;
          rst_evt    = started_ff & fall;
        end
        hlt_pkg::MODE_OS_RLOW: begin
          start_edge = rise;
          rst_evt    = started_ff & ~ext_v;
        end
        hlt_pkg::MODE_OS_FHIGH: begin
          start_edge = fall;
          rst_evt    = started_ff & ext_v;
        end
        default: gate_ok = 1'b1;
      endcase
      // ext acts whenever run is set, no freeze gating
      if (!run_v) begin
        rst_evt = 1'b0;
      end
    end

    // edge-start one-shots need a fresh edge after run rises
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        started_ff <= 1'b0;
        done_ff    <= 1'b0;
      end else if (!run_v) begin
        started_ff <= 1'b0;
        done_ff    <= 1'b0;
      end else begin
        if (one_shot & start_edge) begin
          started_ff <= 1'b1;
        end
        // done covers the sync lag until run is seen low
        if (match & one_shot) begin
          done_ff <= 1'b1;
        end
      end
    end

    assign counting = run_v & gate_ok & ~rst_evt & ~done_ff &
                      (~one_shot | started_ff | (mode_ff[i] == hlt_pkg::MODE_OS_SW));
    assign tick     = counting & (presc_ff == pre_mask(pre_sel_ff[i]));
    assign match    = tick & (count_ff[i] == period_ff[i]);
    assign post_hit = match & (post_ff == post_sel_ff[i]);
    assign scale_clr = wr_cnt | wr_ctl | rst_evt | (one_shot & run_rise);

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        presc_ff <= hlt_pkg::PRESC_RST;
      end else if (scale_clr) begin
        presc_ff <= hlt_pkg::PRESC_RST;
      end else if (tick) begin
        presc_ff <= hlt_pkg::PRESC_RST;
      end else if (counting) begin
        presc_ff <= presc_ff + 7'h01;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        post_ff <= hlt_pkg::POST_RST;
      end else if (scale_clr) begin
        post_ff <= hlt_pkg::POST_RST;
      end else if (post_hit) begin
        post_ff <= hlt_pkg::POST_RST;
      end else if (match) begin
        post_ff <= post_ff + 4'h1;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        count_ff[i] <= hlt_pkg::COUNT_RST;
      end else if (wr_cnt) begin
        count_ff[i] <= wb_dat_i[7:0];
      end else if (rst_evt | match) begin
        count_ff[i] <= hlt_pkg::COUNT_RST;
      end else if (tick) begin
        count_ff[i] <= count_ff[i] + 8'h01;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        period_ff[i] <= hlt_pkg::PERIOD_RST;
      end else if (wr_per) begin
        period_ff[i] <= wb_dat_i[7:0];
      end
    end

    // control write touches only control fields
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        run_ff[i]      <= hlt_pkg::CTRL_RST[hlt_pkg::CTRL_RUN_BIT];
        pre_sel_ff[i]  <= hlt_pkg::CTRL_RST[hlt_pkg::CTRL_PRE_LSB +: 3];
        post_sel_ff[i] <= hlt_pkg::CTRL_RST[hlt_pkg::CTRL_POST_LSB +: 4];
      end else if (wr_ctl) begin
        run_ff[i]      <= wb_dat_i[hlt_pkg::CTRL_RUN_BIT];
        pre_sel_ff[i]  <= wb_dat_i[hlt_pkg::CTRL_PRE_LSB +: 3];
        post_sel_ff[i] <= wb_dat_i[hlt_pkg::CTRL_POST_LSB +: 4];
      end else if (match & one_shot) begin
        run_ff[i] <= 1'b0;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mode_ff[i] <= hlt_pkg::MODE_RST;
        sync_ff[i] <= hlt_pkg::SYNC_RST;
        src_ff[i]  <= '0;
        ien_ff[i]  <= 1'b0;
      end else if (wr_ctl1) begin
        if (wb_sel_i[0]) begin
          mode_ff[i] <= wb_dat_i[hlt_pkg::CTRL1_MODE_LSB +: 4];
          sync_ff[i] <= wb_dat_i[hlt_pkg::CTRL1_SYNC_BIT];
        end
        if (wb_sel_i[1]) begin
          src_ff[i] <= wb_dat_i[hlt_pkg::CTRL1_SRC_LSB +: SRC_W];
        end
        if (wb_sel_i[2]) begin
          ien_ff[i] <= wb_dat_i[hlt_pkg::CTRL1_IEN_BIT];
        end
      end
    end

    // sticky flag, write one clears, set wins
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        flag_ff[i] <= 1'b0;
      end else if (post_hit) begin
        flag_ff[i] <= 1'b1;
      end else if (wr_ctl1 & wb_sel_i[2] & wb_dat_i[hlt_pkg::CTRL1_FLAG_BIT]) begin
        flag_ff[i] <= 1'b0;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        out_ff[i] <= '0;
      end else begin
        out_ff[i].count      <= count_ff[i];
        out_ff[i].period     <= period_ff[i];
        out_ff[i].match      <= match;
        out_ff[i].postscaled <= post_hit;
        out_ff[i].irq        <= (flag_ff[i] | post_hit) & ien_ff[i];
      end
    end

    assign tmr_o[i] = out_ff[i];
  end

endmodule

/* test/hlt_timer_assertions.sv */
// concurrent checks on the period timer ports
`timescale 1ns/1ns
module hlt_timer_assertions #(
  parameter int NT    = 3,
  parameter int NSRC  = 8,
  parameter int SRC_W = 3
) (
  // clock and reset
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  // wishbone
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [hlt_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]                wb_sel_i,
  input wire logic [31:0]               wb_dat_i,
  input wire logic [31:0]               wb_dat_o,
  input wire logic                      wb_ack_o,
  // timer side
  input wire logic [NSRC-1:0]           ext_reset_i,
  input hlt_pkg::hlt_out_t              tmr_o [NT]
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [2:0] up_ff;
  logic [2:0] wr_ff;
  // past-based checks wait until the reset flush has left tmr_o
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_ff <= 3'h0;
    end else if (up_ff != 3'h7) begin
      up_ff <= up_ff + 3'h1;
    end
  end
  // bus writes reach tmr_o two edges after the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ff <= 3'h0;
    end else begin
      wr_ff <= {wr_ff[1:0], wb_ack_o && wb_we_i};
    end
  end

  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  ack_reply_a: assert property (req_s |=> wb_ack_o)
    else $error("request got no ack in the next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack wider than one cycle");
  hole_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[5:4] == 2'h3
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");

  for (genvar t = 0; t < NT; t++) begin : g_tmr
    reset_values_a: assert property ($fell(rst_i) |-> ##[0:2]
      (tmr_o[t].count == 8'h00 && tmr_o[t].period == hlt_pkg::PERIOD_RST))
      else $error("count or period wrong after reset");
    period_hold_a: assert property (up_ff == 3'h7 && $changed(tmr_o[t].period)
      |-> wr_ff[1]) else $error("period changed without a write");
    count_step_a: assert property (up_ff == 3'h7 && !wr_ff[1] |->
      tmr_o[t].count == $past(tmr_o[t].count) || tmr_o[t].count == 8'h00 ||
      tmr_o[t].count == 8'($past(tmr_o[t].count) + 8'h01))
      else $error("count moved by other than one");
    match_equal_a: assert property (tmr_o[t].match |->
      tmr_o[t].count == tmr_o[t].period) else $error("match without equal period");
    match_zero_a: assert property (tmr_o[t].match |=> tmr_o[t].count == 8'h00)
      else $error("count not zero after match");
    post_on_match_a: assert property (tmr_o[t].postscaled |-> tmr_o[t].match)
      else $error("postscaled pulse without a match");
    irq_cause_a: assert property ($rose(tmr_o[t].irq) |-> tmr_o[t].postscaled ||
      (|wr_ff)) else $error("irq rose without a cause");
  end
endmodule

/* test/hlt_src_model.sv */
// model of the on-chip logic driving the external reset sources
`timescale 1ns/1ns
module hlt_src_model #(
  parameter int NSRC = 8
) (
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  // wanted and driven levels
  input  wire logic [NSRC-1:0] want_i,
  output logic      [NSRC-1:0] ext_o
);
  logic [3:0] gap_ff [NSRC];
  always_ff @(posedge clk_i) begin
    for (int b = 0; b < NSRC; b++) begin
      if (rst_i) begin
        ext_o[b] <= 1'b0;
        gap_ff[b] <= 4'h0;
      end else if (want_i[b] != ext_o[b] && gap_ff[b] >= 4'h6) begin
        ext_o[b] <= want_i[b];
        gap_ff[b] <= 4'h0;
      end else if (gap_ff[b] != 4'hF) begin
        gap_ff[b] <= gap_ff[b] + 4'h1;
      end
    end
  end
endmodule

/* test/hlt_timer_test.sv */
// self-checking bench for the three period timers
`timescale 1ns/1ns
module hlt_timer_test;
  localparam int NT = 3;
  // mode, new level, dropped to zero, still moving
  localparam logic [6:0] XT [12] = '{7'h0C, 7'h10, 7'h1F, 7'h1B, 7'h27, 7'h21,
                                     7'h2D, 7'h2B, 7'h32, 7'h35, 7'h3E, 7'h39};
  // one-shot mode, level before the start edge, held at zero once level returns
  localparam logic [5:0] OS [7] = '{6'h24, 6'h2A, 6'h2C, 6'h30, 6'h36, 6'h39, 6'h3F};
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc   = 1'b0;
  logic              stb   = 1'b0;
  logic              we    = 1'b0;
  logic [7:0]        adr   = 8'h00;
  logic [31:0]       dw    = 32'h0;
  logic [3:0]        sel   = 4'h0;
  logic [3:0]        lanes = 4'hF;
  logic [7:0]        want  = 8'h00;
  logic [7:0]        rnd   = 8'h34;
  logic [31:0]       dr;
  logic              ack;
  logic [7:0]        ext;
  hlt_pkg::hlt_out_t tmr [NT];
  logic [31:0]       exp_q [$];
  int                n_fail = 0;
  int                checks = 0;

  always #4 clk_i = ~clk_i;

  hlt_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .ext_reset_i(ext), .tmr_o(tmr));
  hlt_src_model u_src (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .ext_o(ext));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one classic cycle; returns one edge after release so cyc idles a cycle
  // waits for ack as long as it takes; only the watchdog ends a hang
  task automatic bus(input int i, input int r, input logic w, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lanes;
    adr <= 8'(i * 16 + r * 4);
    dw <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input int i, input int r, input logic [31:0] e);
    exp_q.push_back(e);
    bus(i, r, 1'b0, 32'h0);
  endtask

  task automatic hunt(input int i, input bit p, input int lim, output int g);
    g = 0;
    do begin
      @(posedge clk_i);
      g++;
    end while ((p ? tmr[i].postscaled : tmr[i].match) !== 1'b1 && g < lim);
  endtask

  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) n_fail++;
      else check(dr, exp_q.pop_front());
    end
  end

  initial begin
    #(8 * 40000);
    n_fail++;
    results();
  end

  initial begin
    int g;
    logic [6:0] e;
    logic drop;
    logic [7:0] prev;
    logic [5:0] o;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 4; i++) begin
      rd(i, 0, 32'h0);
      rd(i, 1, i < 3 ? 32'hFF : 32'h0);
      rd(i, 2, 32'h0);
      rd(i, 3, i < 3 ? 32'h10 : 32'h0);
    end
    bus(3, 1, 1'b1, 32'h5A);
    rd(0, 1, 32'hFF);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      bus(i, 0, 1'b1, {24'h0, rnd});
      bus(i, 1, 1'b1, {24'h0, ~rnd});
      bus(i, 2, 1'b1, 32'h70);
      rd(i, 0, {24'h0, rnd});
      rd(i, 1, {24'h0, ~rnd});
      rd(i, 2, 32'h70);
    end
    bus(1, 1, 1'b1, 32'h1);
    for (int s = 0; s < 8; s++) begin
      bus(1, 2, 1'b1, 32'h80 | 32'(s << 4));
      repeat (3) hunt(1, 0, 600, g);
      check(32'(g), 32'(2 << s));
    end
    bus(0, 1, 1'b1, 32'h0);
    for (int s = 0; s < 16; s++) begin
      bus(0, 2, 1'b1, 32'h80 | 32'(s));
      repeat (3) hunt(0, 1, 600, g);
      check(32'(g), 32'(s + 1));
    end
    // lane 0 off: period write must be ignored
    lanes = 4'hE;
    bus(0, 1, 1'b1, 32'h11);
    lanes = 4'hF;
    rd(0, 1, 32'h0);
    rd(0, 3, 32'h10010);
    check(32'(tmr[0].irq), 32'h0);
    bus(0, 3, 1'b1, 32'h20010);
    repeat (2) @(posedge clk_i);
    check(32'(tmr[0].irq), 32'h1);
    bus(0, 2, 1'b1, 32'h0);
    repeat (4) @(posedge clk_i);
    bus(0, 3, 1'b1, 32'h30010);
    repeat (2) @(posedge clk_i);
    check(32'(tmr[0].irq), 32'h0);
    rd(0, 3, 32'h20010);
    bus(2, 1, 1'b1, 32'h4);
    bus(2, 0, 1'b1, 32'h0);
    bus(2, 3, 1'b1, 32'h18);
    bus(2, 2, 1'b1, 32'h81);
    hunt(2, 0, 40, g);
    check(32'(g < 40), 32'h1);
    repeat (10) @(posedge clk_i);
    rd(2, 2, 32'h01);
    hunt(2, 0, 30, g);
    check(32'(g), 32'd30);
    rd(2, 0, 32'h0);
    bus(2, 2, 1'b1, 32'h81);
    hunt(2, 1, 40, g);
    check(32'(g), 32'd40);
    rd(2, 2, 32'h01);
    bus(1, 1, 1'b1, 32'hFF);
    for (int k = 0; k < 12; k++) begin
      e = XT[k];
      bus(1, 2, 1'b1, 32'h0);
      want[3] <= ~e[2];
      bus(1, 3, 1'b1, 32'h310 | 32'(e[6:3]));
      bus(1, 0, 1'b1, 32'h0);
      bus(1, 2, 1'b1, 32'h80);
      repeat (40) @(posedge clk_i);
      want[3] <= e[2];
      drop = 1'b0;
      prev = tmr[1].count;
      repeat (12) begin
        @(posedge clk_i);
        if (tmr[1].count === 8'h00 && prev !== 8'h00) drop = 1'b1;
        prev = tmr[1].count;
      end
      repeat (8) @(posedge clk_i);
      check(32'({drop, tmr[1].count !== prev}), 32'(e[1:0]));
    end
    // edge-started one-shots: no count before the edge, then run or reset
    bus(2, 1, 1'b1, 32'hFF);
    for (int k = 0; k < 7; k++) begin
      o = OS[k];
      bus(2, 2, 1'b1, 32'h0);
      want[0] <= o[1];
      bus(2, 3, 1'b1, 32'h10 | 32'(o[5:2]));
      bus(2, 0, 1'b1, 32'h0);
      bus(2, 2, 1'b1, 32'h80);
      repeat (20) @(posedge clk_i);
      check(32'(tmr[2].count), 32'h0);
      want[0] <= ~o[1];
      repeat (20) @(posedge clk_i);
      check(32'(tmr[2].count > 8'h08), 32'h1);
      want[0] <= o[1];
      repeat (20) @(posedge clk_i);
      check(32'(tmr[2].count == 8'h00), 32'(o[0]));
    end
    // reset in mid-run restores period, count and timer_control_1 of instance 2
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(2, 1, 32'hFF);
    rd(2, 0, 32'h0);
    rd(2, 3, 32'h10);
    results();
  end
endmodule

bind hlt_timer hlt_timer_assertions #(.NT(NT), .NSRC(NSRC), .SRC_W(SRC_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .ext_reset_i(ext_reset_i), .tmr_o(tmr_o));
